// [asx_regs.svh]
/*
 Register offsets, field positions, reset values and counts of the serial port.
 Assumes byte addresses on a 12-bit Avalon-MM address, one 32-bit word each.
*/
`ifndef ASX_REGS_SVH
`define ASX_REGS_SVH
// Byte offsets
`define ASX_A_DR 12'h000
`define ASX_A_RSR 12'h004
`define ASX_A_FR 12'h018
`define ASX_A_IBRD 12'h024
`define ASX_A_FBRD 12'h028
`define ASX_A_LCRH 12'h02C
`define ASX_A_CTL 12'h030
`define ASX_A_IFLS 12'h034
`define ASX_A_IM 12'h038
`define ASX_A_RIS 12'h03C
`define ASX_A_MIS 12'h040
`define ASX_A_ICR 12'h044
// Control bits and reset value
`define ASX_CTL_EN 0
`define ASX_CTL_LBE 7
`define ASX_CTL_TXE 8
`define ASX_CTL_RXE 9
`define ASX_CTL_RST 10'h300
// Internal 30-bit line register: integer, fraction, line control
`define ASX_LCR_INT 29:14
`define ASX_LCR_FRAC 13:8
`define ASX_LCR_LINE 7:0
`define ASX_LCR_PEN 1
`define ASX_LCR_EPS 2
`define ASX_LCR_STP2 3
`define ASX_LCR_FEN 4
`define ASX_LCR_WLEN 6:5
`define ASX_LCR_SPS 7
// Level select: tx in low field, rx in high field
`define ASX_IFLS_TX 2:0
`define ASX_IFLS_RX 5:3
`define ASX_IFLS_RST 6'h12
// Event bits in raw, mask, masked and clear registers
`define ASX_EV_RX 4
`define ASX_EV_TX 5
`define ASX_EV_RT 6
`define ASX_EV_FE 7
`define ASX_EV_PE 8
`define ASX_EV_BE 9
`define ASX_EV_OE 10
// Flag register bits
`define ASX_FR_BUSY 3
`define ASX_FR_RX_FIFO_EMPTY_FLAG 4
`define ASX_FR_TX_FIFO_FULL_FLAG 5
`define ASX_FR_RX_FIFO_FULL_FLAG 6
`define ASX_FR_TX_FIFO_EMPTY_FLAG 7
// Status bits of a receive word, and of the receive status register
`define ASX_W_FE 8
`define ASX_W_PE 9
`define ASX_W_BE 10
`define ASX_W_OE 11
`define ASX_S_OE 3
// Depths, levels and tick counts
`define ASX_DEPTH 5'h10
`define ASX_LVL_1 5'h02
`define ASX_LVL_2 5'h04
`define ASX_LVL_4 5'h08
`define ASX_LVL_6 5'h0C
`define ASX_LVL_7 5'h0E
`define ASX_START_TICK 4'h7
`define ASX_BIT_TICK 4'hF
`define ASX_RT_TICKS 9'h1FF
// Level history out of reset: tx at or below level, rx below level
`define ASX_LVL_PREV_RST 2'h1
`endif

// [asx_pkg.sv]
/*
 Types of the serial port: state codes of both shift engines.
 Assumes asx_regs.svh supplies all numbers.
*/
`default_nettype none
package asx_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
		TX_PAR = 3'b011, TX_STOP = 3'b100
	} asx_tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
		RX_PAR = 3'b011, RX_STOP = 3'b100, RX_BRK = 3'b101
	} asx_rx_st_t;
endpackage
`default_nettype wire

// [asx_uart.sv]
/*
 Asynchronous serial transmitter and receiver with Avalon-MM register slave.
 Assumes one 100 MHz clock, inputs synchronous to it, a software master
 that keeps its request until waitrequest is seen low.
*/
`timescale 1ns/1ns
`default_nettype none
`include "asx_regs.svh"
module asx_uart (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic serial_rx_line,
	output logic serial_tx_line,
	output logic irq
);
	logic [9:0] ctl_r;
	logic [15:0] ibrd_r;
	logic [5:0] fbrd_r;
	logic [29:0] lcr_r;
	logic [5:0] ifls_r;
	logic [10:0] mask_r;
	logic [10:0] raw_r;
	logic [10:0] ev;
	logic [3:0] rsr_r;
	logic [31:0] rd_mux;
	logic [31:0] fr;
	logic wr_go, rd_go, tick, busy, rx_line, port_on;
	logic [15:0] bcnt_r;
	logic [5:0] bacc_r;
	logic [6:0] bsum;
	logic [7:0] tx_mem [0:15];
	logic [11:0] rx_mem [0:15];
	logic [3:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	logic [4:0] tx_cnt_r, rx_cnt_r, depth;
	logic tx_push, tx_pop, tx_full, rx_push, rx_pop, rx_full;
	asx_pkg::asx_tx_st_t tx_st_r;
	asx_pkg::asx_rx_st_t rx_st_r;
	logic [3:0] tx_tk_r, rx_tk_r;
	logic [2:0] tx_bit_r, rx_bit_r, last_bit;
	logic [7:0] tx_sh_r, rx_sh_r, dmask, rx_data;
	logic tx_adv, rx_smp, rx_zero_r, rx_pe_r, oe_pend_r, rx_done;
	logic [11:0] rx_word, rx_head;
	logic [8:0] rt_cnt_r;
	logic [1:0] lvl_prev_r;
	logic tx_lvl, rx_lvl;
	logic rx_prev_r;
	logic [7:0] tx_byte_r;

	// Address match of the request on the bus
	function automatic logic hit(input logic [11:0] a);
		hit = avs_address == a;
	endfunction

	// FIFO trigger threshold in entries
	function automatic logic [4:0] lvl_fn(input logic [2:0] sel);
		case (sel)
			3'h0: lvl_fn = `ASX_LVL_1;
			3'h1: lvl_fn = `ASX_LVL_2;
			3'h3: lvl_fn = `ASX_LVL_6;
			3'h4: lvl_fn = `ASX_LVL_7;
			default: lvl_fn = `ASX_LVL_4;
		endcase
	endfunction

	// Parity bit for a character under the current line settings
	function automatic logic par_fn(input logic [7:0] d);
		if (lcr_r[`ASX_LCR_SPS])
			par_fn = ~lcr_r[`ASX_LCR_EPS];
		else
			par_fn = (^(d & dmask)) ^ ~lcr_r[`ASX_LCR_EPS];
	endfunction

	assign wr_go = avs_write & ~avs_waitrequest;
	assign rd_go = avs_read & ~avs_waitrequest;
	assign port_on = ctl_r[`ASX_CTL_EN];
	assign depth = lcr_r[`ASX_LCR_FEN] ? `ASX_DEPTH : 5'h01;
	assign dmask = 8'hFF >> (2'h3 - lcr_r[`ASX_LCR_WLEN]);
	assign last_bit = {1'b0, lcr_r[`ASX_LCR_WLEN]} + 3'h4;
	assign rx_line = ctl_r[`ASX_CTL_LBE] ? serial_tx_line : serial_rx_line;

	// Bus slave: one wait cycle, then the answer; readdata is sampled then
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else if ((avs_read | avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			if (avs_read)
				avs_readdata <= rd_mux;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Flag word
	always_comb begin
		fr = 32'h0;
		fr[`ASX_FR_BUSY] = busy;
		fr[`ASX_FR_RX_FIFO_EMPTY_FLAG] = rx_cnt_r == 5'h0;
		fr[`ASX_FR_TX_FIFO_FULL_FLAG] = tx_full;
		fr[`ASX_FR_RX_FIFO_FULL_FLAG] = rx_full;
		fr[`ASX_FR_TX_FIFO_EMPTY_FLAG] = tx_cnt_r == 5'h0;
	end

	// Read multiplexer; unmapped offsets read zero
	always_comb begin
		case (avs_address)
			`ASX_A_DR: rd_mux = {20'h0, rx_head};
			`ASX_A_RSR: rd_mux = {28'h0, rsr_r};
			`ASX_A_FR: rd_mux = fr;
			`ASX_A_IBRD: rd_mux = {16'h0, ibrd_r};
			`ASX_A_FBRD: rd_mux = {26'h0, fbrd_r};
			`ASX_A_LCRH: rd_mux = {24'h0, lcr_r[`ASX_LCR_LINE]};
			`ASX_A_CTL: rd_mux = {22'h0, ctl_r};
			`ASX_A_IFLS: rd_mux = {26'h0, ifls_r};
			`ASX_A_IM: rd_mux = {21'h0, mask_r};
			`ASX_A_RIS: rd_mux = {21'h0, raw_r};
			`ASX_A_MIS: rd_mux = {21'h0, raw_r & mask_r};
			default: rd_mux = 32'h0;
		endcase
	end

	// Control and level registers; both direction enables set out of reset, port enable clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= `ASX_CTL_RST;
			ifls_r <= `ASX_IFLS_RST;
			mask_r <= 11'h0;
		end else if (wr_go) begin
			if (hit(`ASX_A_CTL))
				ctl_r <= avs_writedata[9:0];
			if (hit(`ASX_A_IFLS))
				ifls_r <= avs_writedata[5:0];
			if (hit(`ASX_A_IM))
				mask_r <= avs_writedata[10:0];
		end
	end

	// Divisor staging; only a line-control write commits all 30 bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ibrd_r <= 16'h0;
			fbrd_r <= 6'h0;
			lcr_r <= 30'h0;
		end else if (wr_go) begin
			if (hit(`ASX_A_IBRD))
				ibrd_r <= avs_writedata[15:0];
			if (hit(`ASX_A_FBRD))
				fbrd_r <= avs_writedata[5:0];
			if (hit(`ASX_A_LCRH))
				lcr_r <= {ibrd_r, fbrd_r, avs_writedata[7:0]};
		end
	end

	// Fractional divider: period is integer part plus carry of the fraction
	assign bsum = {1'b0, bacc_r} + {1'b0, lcr_r[`ASX_LCR_FRAC]};
	assign tick = (lcr_r[`ASX_LCR_INT] != 16'h0) && (bcnt_r == 16'h0);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt_r <= 16'h0;
			bacc_r <= 6'h0;
		end else if (tick) begin
			bcnt_r <= lcr_r[`ASX_LCR_INT] - 16'h1 + {15'h0, bsum[6]};
			bacc_r <= bsum[5:0];
		end else if (bcnt_r != 16'h0) begin
			bcnt_r <= bcnt_r - 16'h1;
		end
	end

	// Transmit FIFO; a write while full is dropped
	assign tx_full = tx_cnt_r >= depth;
	assign tx_push = wr_go && hit(`ASX_A_DR) && !tx_full;
	always_ff @(posedge clk) begin
		if (tx_push)
			tx_mem[tx_wp_r] <= avs_writedata[7:0];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp_r <= 4'h0;
			tx_rp_r <= 4'h0;
			tx_cnt_r <= 5'h0;
		end else begin
			tx_wp_r <= tx_wp_r + {3'h0, tx_push};
			tx_rp_r <= tx_rp_r + {3'h0, tx_pop};
			tx_cnt_r <= tx_cnt_r + {4'h0, tx_push} - {4'h0, tx_pop};
		end
	end

	// Transmit engine; enable is looked at only between characters
	assign tx_pop = (tx_st_r == asx_pkg::TX_IDLE) && (tx_cnt_r != 5'h0) &&
		port_on && ctl_r[`ASX_CTL_TXE];
	assign tx_adv = tick && (tx_tk_r == `ASX_BIT_TICK);
	assign busy = (tx_cnt_r != 5'h0) || (tx_st_r != asx_pkg::TX_IDLE);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_r <= asx_pkg::TX_IDLE;
			tx_tk_r <= 4'h0;
			tx_bit_r <= 3'h0;
			tx_sh_r <= 8'h0;
			tx_byte_r <= 8'h0;
			serial_tx_line <= 1'b1;
		end else begin
			if (tick && tx_st_r != asx_pkg::TX_IDLE)
				tx_tk_r <= tx_tk_r + 4'h1;
			unique case (tx_st_r)
				asx_pkg::TX_IDLE: begin
					serial_tx_line <= 1'b1;
					tx_tk_r <= 4'h0;
					if (tx_pop) begin
						tx_sh_r <= tx_mem[tx_rp_r];
						tx_byte_r <= tx_mem[tx_rp_r];
						serial_tx_line <= 1'b0;
						tx_st_r <= asx_pkg::TX_START;
					end
				end
				asx_pkg::TX_START: if (tx_adv) begin
					serial_tx_line <= tx_sh_r[0];
					tx_bit_r <= 3'h0;
					tx_st_r <= asx_pkg::TX_DATA;
				end
				asx_pkg::TX_DATA: if (tx_adv) begin
					if (tx_bit_r == last_bit) begin
						if (lcr_r[`ASX_LCR_PEN]) begin
							// Own copy: a full FIFO may already reuse the popped slot
							serial_tx_line <= par_fn(tx_byte_r);
							tx_st_r <= asx_pkg::TX_PAR;
						end else begin
							serial_tx_line <= 1'b1;
							tx_st_r <= asx_pkg::TX_STOP;
						end
						tx_bit_r <= 3'h0;
					end else begin
						serial_tx_line <= tx_sh_r[1];
						tx_sh_r <= tx_sh_r >> 1;
						tx_bit_r <= tx_bit_r + 3'h1;
					end
				end
				asx_pkg::TX_PAR: if (tx_adv) begin
					serial_tx_line <= 1'b1;
					tx_st_r <= asx_pkg::TX_STOP;
				end
				asx_pkg::TX_STOP: if (tx_adv) begin
					if (lcr_r[`ASX_LCR_STP2] && tx_bit_r == 3'h0)
						tx_bit_r <= 3'h1;
					else
						tx_st_r <= asx_pkg::TX_IDLE;
				end
				default: tx_st_r <= asx_pkg::TX_IDLE;
			endcase
		end
	end

	// Receive word assembly at the stop-bit sample
	assign rx_smp = tick && (rx_tk_r == `ASX_BIT_TICK);
	assign rx_data = rx_sh_r >> (2'h3 - lcr_r[`ASX_LCR_WLEN]);
	assign rx_done = (rx_st_r == asx_pkg::RX_STOP) && rx_smp;
	always_comb begin
		rx_word = {4'h0, rx_data};
		rx_word[`ASX_W_OE] = oe_pend_r;
		rx_word[`ASX_W_PE] = rx_pe_r;
		if (!rx_line && rx_zero_r) begin
			rx_word[7:0] = 8'h00;
			rx_word[`ASX_W_BE] = 1'b1;
		end else if (!rx_line) begin
			rx_word[`ASX_W_FE] = 1'b1;
		end
	end

	// Line one cycle late; idle-high reset value avoids a false edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rx_prev_r <= 1'b1;
		else
			rx_prev_r <= rx_line;
	end

	// Receive engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= asx_pkg::RX_IDLE;
			rx_tk_r <= 4'h0;
			rx_bit_r <= 3'h0;
			rx_sh_r <= 8'h0;
			rx_zero_r <= 1'b0;
			rx_pe_r <= 1'b0;
		end else begin
			if (tick)
				rx_tk_r <= rx_tk_r + 4'h1;
			unique case (rx_st_r)
				asx_pkg::RX_IDLE: begin
					rx_tk_r <= 4'h0;
					// A falling edge only: a line still low after a bad stop is no start
					if (rx_prev_r && !rx_line && port_on && ctl_r[`ASX_CTL_RXE])
						rx_st_r <= asx_pkg::RX_START;
				end
				asx_pkg::RX_START: if (tick && rx_tk_r == `ASX_START_TICK) begin
					rx_tk_r <= 4'h0;
					rx_bit_r <= 3'h0;
					rx_zero_r <= 1'b1;
					rx_pe_r <= 1'b0;
					// A short glitch must not start a character
					rx_st_r <= rx_line ? asx_pkg::RX_IDLE : asx_pkg::RX_DATA;
				end
				asx_pkg::RX_DATA: if (rx_smp) begin
					rx_sh_r <= {rx_line, rx_sh_r[7:1]};
					rx_zero_r <= rx_zero_r & ~rx_line;
					rx_bit_r <= rx_bit_r + 3'h1;
					if (rx_bit_r == last_bit)
						rx_st_r <= lcr_r[`ASX_LCR_PEN] ? asx_pkg::RX_PAR : asx_pkg::RX_STOP;
				end
				asx_pkg::RX_PAR: if (rx_smp) begin
					rx_pe_r <= rx_line != par_fn(rx_data);
					rx_zero_r <= rx_zero_r & ~rx_line;
					rx_st_r <= asx_pkg::RX_STOP;
				end
				asx_pkg::RX_STOP: if (rx_smp) begin
					// After a break only a high line re-arms the start search
					rx_st_r <= (!rx_line && rx_zero_r) ? asx_pkg::RX_BRK : asx_pkg::RX_IDLE;
				end
				asx_pkg::RX_BRK: if (rx_line)
					rx_st_r <= asx_pkg::RX_IDLE;
				default: rx_st_r <= asx_pkg::RX_IDLE;
			endcase
		end
	end

	// Receive FIFO; a word arriving while full is lost and marked overrun
	assign rx_full = rx_cnt_r >= depth;
	assign rx_push = rx_done && !rx_full;
	// Pop where readdata is captured, so a word landing meanwhile is not lost
	assign rx_pop = avs_read && avs_waitrequest && hit(`ASX_A_DR) && (rx_cnt_r != 5'h0);
	assign rx_head = (rx_cnt_r != 5'h0) ? rx_mem[rx_rp_r] : 12'h0;
	always_ff @(posedge clk) begin
		if (rx_push)
			rx_mem[rx_wp_r] <= rx_word;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp_r <= 4'h0;
			rx_rp_r <= 4'h0;
			rx_cnt_r <= 5'h0;
		end else begin
			rx_wp_r <= rx_wp_r + {3'h0, rx_push};
			rx_rp_r <= rx_rp_r + {3'h0, rx_pop};
			rx_cnt_r <= rx_cnt_r + {4'h0, rx_push} - {4'h0, rx_pop};
		end
	end

	// Overrun carry-over and receive status; a new overrun beats a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_pend_r <= 1'b0;
			rsr_r <= 4'h0;
		end else begin
			if (rx_done && rx_full)
				oe_pend_r <= 1'b1;
			else if (rx_push)
				oe_pend_r <= 1'b0;
			if (wr_go && hit(`ASX_A_RSR))
				rsr_r <= 4'h0;
			else if (rx_pop)
				rsr_r <= rx_head[11:8];
			if (rx_done && rx_full)
				rsr_r[`ASX_S_OE] <= 1'b1;
		end
	end

	// Idle timer in ticks; restarts on any receive FIFO traffic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rt_cnt_r <= 9'h0;
		else if (rx_cnt_r == 5'h0 || rx_push || rx_pop)
			rt_cnt_r <= 9'h0;
		else if (tick && rt_cnt_r != `ASX_RT_TICKS)
			rt_cnt_r <= rt_cnt_r + 9'h1;
	end

	// Event sources; level events fire on the crossing only
	assign tx_lvl = tx_cnt_r <= lvl_fn(ifls_r[`ASX_IFLS_TX]);
	assign rx_lvl = rx_cnt_r >= lvl_fn(ifls_r[`ASX_IFLS_RX]);
	always_comb begin
		ev = 11'h0;
		ev[`ASX_EV_TX] = tx_lvl & ~lvl_prev_r[0];
		ev[`ASX_EV_RX] = rx_lvl & ~lvl_prev_r[1];
		ev[`ASX_EV_RT] = (rt_cnt_r == `ASX_RT_TICKS) && (rx_cnt_r != 5'h0);
		ev[`ASX_EV_FE] = rx_push && rx_word[`ASX_W_FE];
		ev[`ASX_EV_PE] = rx_push && rx_word[`ASX_W_PE];
		ev[`ASX_EV_BE] = rx_push && rx_word[`ASX_W_BE];
		ev[`ASX_EV_OE] = rx_done && rx_full;
	end

	// Raw status: set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_r <= 11'h0;
			lvl_prev_r <= `ASX_LVL_PREV_RST;
			irq <= 1'b0;
		end else begin
			lvl_prev_r <= {rx_lvl, tx_lvl};
			if (wr_go && hit(`ASX_A_ICR))
				raw_r <= (raw_r & ~avs_writedata[10:0]) | ev;
			else
				raw_r <= raw_r | ev;
			irq <= |(raw_r & mask_r);
		end
	end

	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	sequence s_good_start;
		rx_st_r == asx_pkg::RX_START && tick && rx_tk_r == `ASX_START_TICK;
	endsequence

	a_bus_ack: assert property (@(posedge clk) disable iff (!rst_n)
		s_req |=> s_ack) else $error("bus answer not one cycle");
	a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
		tx_st_r == asx_pkg::TX_START |-> !serial_tx_line) else $error("start bit not low");
	a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
		tx_st_r == asx_pkg::TX_STOP |-> serial_tx_line) else $error("stop bit not high");
	a_busy_frame: assert property (@(posedge clk) disable iff (!rst_n)
		tx_pop |=> busy [*8]) else $error("busy dropped during frame");
	a_false_start: assert property (@(posedge clk) disable iff (!rst_n)
		s_good_start ##0 rx_line |=> rx_st_r == asx_pkg::RX_IDLE) else $error("false start kept");
	a_true_start: assert property (@(posedge clk) disable iff (!rst_n)
		s_good_start ##0 !rx_line |=> rx_st_r == asx_pkg::RX_DATA) else $error("start lost");
	a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> irq == $past(|(raw_r & mask_r))) else $error("irq not masked raw");
	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		ev[`ASX_EV_OE] |=> raw_r[`ASX_EV_OE]) else $error("event lost");
	a_clear_ok: assert property (@(posedge clk) disable iff (!rst_n)
		wr_go && hit(`ASX_A_ICR) && avs_writedata[`ASX_EV_PE] && !ev[`ASX_EV_PE]
		|=> !raw_r[`ASX_EV_PE]) else $error("clear ignored");
	a_div_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr_go && hit(`ASX_A_LCRH)) |=> $stable(lcr_r)) else $error("line reg moved");
	a_overrun: assert property (@(posedge clk) disable iff (!rst_n)
		rx_done && rx_full |=> rsr_r[`ASX_S_OE] && oe_pend_r) else $error("overrun missed");
	a_one_deep: assert property (@(posedge clk) disable iff (!rst_n)
		tx_push && !lcr_r[`ASX_LCR_FEN] |-> tx_cnt_r == 5'h0) else $error("depth not one");
endmodule
`default_nettype wire

// [asx_remote.sv]
/*
 Remote serial device on the far side of the serial lines.
 Assumes the bench sets bit_clks to the bit period in clocks between frames.
*/
`timescale 1ns/1ns
`default_nettype none
module asx_remote (
	input wire logic clk,
	input wire logic tx_line,
	output var logic rx_line
);
	int bit_clks = 32;
	logic [8:0] got_q[$];
	logic [8:0] w;
	initial rx_line = 1'b1;
	// One frame out: start, data LSB first, one stop of the given level
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (bit_clks) @(posedge clk);
		end
		rx_line <= 1'b1;
		@(posedge clk);
	endtask
	// Low level for a break or a short glitch, then idle high
	task automatic hold_low(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge clk);
		rx_line <= 1'b1;
		@(posedge clk);
	endtask
	// Decoder samples mid-bit, so fractional jitter of the divisor is tolerated
	always begin
		@(negedge tx_line);
		repeat (bit_clks / 2) @(posedge clk);
		if (tx_line === 1'b0) begin
			for (int i = 0; i < 9; i++) begin
				repeat (bit_clks) @(posedge clk);
				w = {tx_line, w[8:1]};
			end
			got_q.push_back(w);
		end
	end
endmodule
`default_nettype wire

// [testbench.sv]
/*
 Self-checking bench of the serial port: bus master, queue model, remote device.
 Assumes the register map of asx_regs.svh and one wait cycle per access.
*/
`timescale 1ns/1ns
`default_nettype none
`include "asx_regs.svh"
module testbench;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest, rx, tx, irq;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [31:0] seed = 32'h00000056;
	int err_total, num_checks;
	logic [8:0] exp_tx[$];
	logic [11:0] exp_rx[$];
	logic [7:0] b;
	asx_uart dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_rx_line(rx), .serial_tx_line(tx),
		.irq(irq));
	asx_remote remote (.clk(clk), .tx_line(tx), .rx_line(rx));
	// Clock of 10 ns
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic tally_and_finish();
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic hang();
		err_total++;
		tally_and_finish();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Avalon-MM access held until waitrequest is seen low
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 200) hang();
		@(posedge clk);
	endtask
	// Model side: every byte written must come out as one frame
	task automatic txb(input logic [7:0] v);
		exp_tx.push_back({1'b1, v});
		bus(1'b1, `ASX_A_DR, {24'h0, v});
	endtask
	task automatic wait_tx();
		int n;
		logic [8:0] g;
		n = 0;
		while (remote.got_q.size() == 0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) hang();
		g = remote.got_q.pop_front();
		chk("tx frame", {23'h0, exp_tx.pop_front()}, {23'h0, g});
	endtask
	task automatic rxb(input logic [7:0] v, input logic stop, input logic [3:0] s);
		remote.send(v, stop);
		exp_rx.push_back({s, v});
	endtask
	task automatic rd_dr();
		bus(1'b0, `ASX_A_DR, 32'h0);
		chk("rx word", {20'h0, exp_rx.pop_front()}, rd);
	endtask
	// Disable, divisors, line control, enable; remote follows the new bit period
	task automatic cfg(input int ib, input int fb, input logic [7:0] lc, input logic [9:0] c);
		bus(1'b1, `ASX_A_CTL, 32'h300);
		bus(1'b1, `ASX_A_IBRD, ib);
		bus(1'b1, `ASX_A_FBRD, fb);
		bus(1'b1, `ASX_A_LCRH, {24'h0, lc});
		bus(1'b1, `ASX_A_CTL, {22'h0, c});
		remote.bit_clks = ib * 16 + fb / 4;
	endtask
	// Watchdog against a hang
	initial begin
		repeat (90000) @(posedge clk);
		hang();
	end
	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 12'h000;
		avs_writedata = 32'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, `ASX_A_CTL, 32'h0);
		chk("ctl reset", 32'h300, rd);
		bus(1'b0, `ASX_A_IFLS, 32'h0);
		chk("ifls reset", 32'h12, rd);
		bus(1'b0, `ASX_A_FR, 32'h0);
		chk("fr reset", 32'h90, rd);
		bus(1'b0, 12'h100, 32'h0);
		chk("unmapped", 32'h0, rd);
		cfg(2, 0, 8'h60, 10'h301);
		for (int i = 0; i < 3; i++) begin
			txb(xs());
			bus(1'b0, `ASX_A_FR, 32'h0);
			chk("busy", 32'h1, {31'h0, rd[3]});
			wait_tx();
		end
		repeat (40) @(posedge clk);
		bus(1'b0, `ASX_A_FR, 32'h0);
		chk("fr idle", 32'h90, rd);
		// Disable in mid-frame: the character still completes
		txb(xs());
		repeat (64) @(posedge clk);
		bus(1'b1, `ASX_A_CTL, 32'h300);
		wait_tx();
		// Staged divisor has no effect until the line control write
		bus(1'b1, `ASX_A_IBRD, 32'h4);
		bus(1'b1, `ASX_A_CTL, 32'h301);
		txb(xs());
		wait_tx();
		cfg(4, 0, 8'h60, 10'h301);
		txb(xs());
		wait_tx();
		// FIFO mode with a fractional divisor, back-to-back traffic
		cfg(2, 8, 8'h70, 10'h301);
		for (int i = 0; i < 4; i++) txb(xs());
		for (int i = 0; i < 4; i++) wait_tx();
		for (int i = 0; i < 3; i++) rxb(xs(), 1'b1, 4'h0);
		repeat (1300) @(posedge clk);
		bus(1'b0, `ASX_A_RIS, 32'h0);
		chk("rx timeout", 32'h1, {31'h0, rd[6]});
		for (int i = 0; i < 3; i++) rd_dr();
		bus(1'b0, `ASX_A_FR, 32'h0);
		chk("rx empty", 32'h1, {31'h0, rd[4]});
		// One-deep holding register: the second character overruns
		cfg(2, 8, 8'h60, 10'h301);
		rxb(xs(), 1'b1, 4'h0);
		remote.send(xs(), 1'b1);
		bus(1'b0, `ASX_A_RIS, 32'h0);
		chk("oe event", 32'h1, {31'h0, rd[10]});
		bus(1'b0, `ASX_A_RSR, 32'h0);
		chk("oe status", 32'h1, {31'h0, rd[3]});
		rd_dr();
		bus(1'b1, `ASX_A_RSR, 32'h0);
		bus(1'b1, `ASX_A_ICR, 32'h7FF);
		// Framing error, masked then unmasked onto irq, then cleared
		// Nonzero data so it is no break; the word carries the earlier overrun
		rxb(xs() | 8'h01, 1'b0, 4'h9);
		rd_dr();
		chk("irq masked", 32'h0, {31'h0, irq});
		bus(1'b1, `ASX_A_IM, 32'h80);
		bus(1'b0, `ASX_A_MIS, 32'h0);
		chk("mis", 32'h80, rd);
		chk("irq on", 32'h1, {31'h0, irq});
		bus(1'b1, `ASX_A_ICR, 32'h80);
		bus(1'b0, `ASX_A_RIS, 32'h0);
		chk("fe cleared", 32'h0, {31'h0, rd[7]});
		chk("irq off", 32'h0, {31'h0, irq});
		// Break yields one zero word, then a normal frame resumes
		remote.hold_low(remote.bit_clks * 20);
		exp_rx.push_back(12'h400);
		rd_dr();
		bus(1'b0, `ASX_A_FR, 32'h0);
		chk("one break word", 32'h1, {31'h0, rd[4]});
		rxb(xs(), 1'b1, 4'h0);
		rd_dr();
		// Glitch shorter than eight ticks is no start bit
		remote.hold_low(6);
		repeat (400) @(posedge clk);
		bus(1'b0, `ASX_A_FR, 32'h0);
		chk("false start", 32'h1, {31'h0, rd[4]});
		// Loopback: own transmission arrives at the receiver
		cfg(2, 8, 8'h60, 10'h381);
		b = xs();
		exp_rx.push_back({4'h0, b});
		exp_tx.push_back({1'b1, b});
		bus(1'b1, `ASX_A_DR, {24'h0, b});
		repeat (500) @(posedge clk);
		wait_tx();
		rd_dr();
		// Even parity in loopback: pin shows parity after data, receiver sees no error
		cfg(2, 8, 8'h66, 10'h381);
		b = xs();
		exp_rx.push_back({4'h0, b});
		exp_tx.push_back({^b, b});
		bus(1'b1, `ASX_A_DR, {24'h0, b});
		repeat (500) @(posedge clk);
		wait_tx();
		rd_dr();
		tally_and_finish();
	end
endmodule
`default_nettype wire
